// ==== ext_isa_cfg.svh ====
`ifndef EXT_ISA_CFG_SVH
`define EXT_ISA_CFG_SVH

// configuration and reset values
`define EXT_ENABLE_RESET     1'b0
`define EXT_OFFSET_LIMIT     8'h5F
`define ACCESS_HIGH_PAGE     4'hF
`define ACCESS_LOW_PAGE      4'h0

// status flag bit positions
`define FLAG_CARRY           0
`define FLAG_DIGIT_CARRY     1
`define FLAG_ZERO            2
`define FLAG_OVERFLOW        3
`define FLAG_NEGATIVE        4

// opcode fields
`define OPC_EXT_GROUP        4'hE
`define OPC_SECOND_WORD      4'hF
`define OPC_SUB_POINTER      4'h9
`define OPC_PUSH_LITERAL     4'hA
`define OPC_MOVE_INDEXED     4'hB
`define OPC_ADD_WORKING      6'h09
`define OPC_CALL_WORKING     16'h0014
`define OPC_MULTIPLY         7'h01
`define OPC_DECREMENT        6'h01
`define PTR_FRAME            2'h2
`define PTR_RETURN           2'h3

`endif

// ==== ext_isa_pkg.sv ====
package ext_isa_pkg;
   typedef logic [11:0] data_addr_type;
   typedef logic [20:0] prog_addr_type;
   typedef enum logic [1:0] {ST_EXEC, ST_MOVE_SECOND, ST_IDLE} exec_state_type;
endpackage : ext_isa_pkg

// ==== addr_form_if.sv ====
`timescale 1ns/1ns
interface addr_form_if;
   import ext_isa_pkg::*;
   logic [7:0]    fileField;
   logic          accessBit;
   logic          extOn;
   logic          forceOffset;
   data_addr_type frameBase;
   logic [7:0]    bankSel;
   data_addr_type effAddr;
   logic          indexed;
   modport former (input fileField, accessBit, extOn, forceOffset, frameBase, bankSel,
                   output effAddr, indexed);
   modport user   (output fileField, accessBit, extOn, forceOffset, frameBase, bankSel,
                   input effAddr, indexed);
endinterface : addr_form_if

// ==== address_former.sv ====
`timescale 1ns/1ns
`include "ext_isa_cfg.svh"
module address_former
   import ext_isa_pkg::*;
(
   // clock for the checks only
   input wire logic   clk_sys,
   input wire logic   reset,
   // address request and result
   addr_form_if.former af
);
   wire logic [7:0]    offset;
   wire logic          lowWindow;
   wire data_addr_type absAddr;

   // forced offsets (moves and pushes) take only the low 7 bits of the file field
   assign offset    = af.forceOffset ? {1'b0, af.fileField[6:0]} : af.fileField;
   assign lowWindow = af.fileField <= `EXT_OFFSET_LIMIT;
   assign af.indexed = af.forceOffset | (af.extOn & ~af.accessBit & lowWindow);
   // absolute form: banked, or access bank split into low ram and high page
   assign absAddr = af.accessBit ? {af.bankSel[3:0], af.fileField} :
                    lowWindow ? {`ACCESS_LOW_PAGE, af.fileField}
                              : {`ACCESS_HIGH_PAGE, af.fileField};
   // frame pointer plus offset, wraps in the 4K data space
   assign af.effAddr = af.indexed ? af.frameBase + {4'h0, offset} : absAddr;

   absolute_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
      (!af.extOn && !af.forceOffset && af.accessBit)
         |-> af.effAddr == {af.bankSel[3:0], af.fileField})
      else $error("banked address wrong with extension off");
   frame_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
      (af.frameBase == 12'h000 && !af.accessBit && !af.forceOffset && lowWindow)
         |-> af.effAddr == {4'h0, af.fileField})
      else $error("zero frame pointer does not match access bank");
endmodule : address_former

// ==== ext_isa_decode.sv ====
`timescale 1ns/1ns
`include "ext_isa_cfg.svh"
module ext_isa_decode
   import ext_isa_pkg::*;
(
   // clock and reset
   input  wire logic          clk_sys,
   input  wire logic          reset,
   // configuration bit
   input  wire logic          extendedSetEnableBit,
   output      logic          extActive,
   // instruction words
   input  wire logic [15:0]   instrWord,
   input  wire logic          instrValid,
   output      logic          instrAccept,
   // core state used by decode
   input  wire logic [7:0]    bankSelectRegister,
   input  wire prog_addr_type nextInstrAddr,
   input  wire prog_addr_type topOfReturnStack,
   input  wire logic [7:0]    counterLatchHigh,
   input  wire logic [4:0]    counterLatchUpper,
   // program flow
   output      logic          pcLoad,
   output      prog_addr_type pcTarget,
   output      logic          stackPush,
   output      prog_addr_type stackPushAddr,
   output      logic          stackPop,
   // data memory
   output      data_addr_type dataAddr,
   output      logic          dataRead,
   input  wire logic [7:0]    dataRdData,
   output      logic          dataWrite,
   output      logic [7:0]    dataWrData,
   // architectural registers
   output      logic [7:0]    workingReg_q,
   output      logic [4:0]    statusFlags_q,
   output      data_addr_type fileSelect0,
   output      data_addr_type fileSelect1,
   output      data_addr_type stackFramePointer
);
   addr_form_if af ();

   logic           cfgMeta_q;
   logic           cfgSync_q;
   logic           captured_q;
   logic           extOn_q;
   exec_state_type state_q;
   exec_state_type state_d;
   logic [7:0]     moveByte_q;
   data_addr_type  pointer_q [3];

   // config pin is asynchronous to the core: two flops, then one capture
   always_ff @(posedge clk_sys) begin
      cfgMeta_q <= extendedSetEnableBit;
      cfgSync_q <= cfgMeta_q;
   end

   // caught once after reset so the mode cannot change under running code
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         captured_q <= 1'b0;
         extOn_q    <= `EXT_ENABLE_RESET;
      end else if (!captured_q) begin
         captured_q <= 1'b1;
         extOn_q    <= cfgSync_q;
      end
   end
   assign extActive = extOn_q;

   // instruction field decode
   wire logic [3:0] topNib   = instrWord[15:12];
   wire logic [3:0] subNib   = instrWord[11:8];
   wire logic [1:0] ptrSel   = instrWord[7:6];
   wire logic [5:0] subLit   = instrWord[5:0];
   wire logic       destBit  = instrWord[9];
   wire logic       execGo   = (state_q == ST_EXEC) && instrValid;
   wire logic       extWord  = extOn_q && (topNib == `OPC_EXT_GROUP);
   wire logic       isSub    = extWord && (subNib == `OPC_SUB_POINTER);
   wire logic       isReturn = isSub && (ptrSel == `PTR_RETURN);
   wire logic       isPush   = extWord && (subNib == `OPC_PUSH_LITERAL);
   wire logic       isMove   = extWord && (subNib == `OPC_MOVE_INDEXED) && instrWord[7];
   wire logic       isCall   = extOn_q && (instrWord == `OPC_CALL_WORKING);
   wire logic       isOrphan = (topNib == `OPC_SECOND_WORD);
   wire logic       isAdd    = instrWord[15:10] == `OPC_ADD_WORKING;
   // every opcode that carries the access bit
   wire logic       byteBitOp = ((topNib >= 4'h1) && (topNib <= 4'hB))
                                || (instrWord[15:9] == `OPC_MULTIPLY)
                                || (instrWord[15:10] == `OPC_DECREMENT);
   wire logic       moveDone  = (state_q == ST_MOVE_SECOND) && instrValid;

   // address former request: moves and pushes use forced offsets
   assign af.extOn       = extOn_q;
   assign af.frameBase   = pointer_q[2];
   assign af.bankSel     = bankSelectRegister;
   assign af.forceOffset = moveDone || (execGo && (isMove || isPush));
   assign af.fileField   = (execGo && isPush) ? 8'h00 :
                           (moveDone || (execGo && isMove)) ? {1'b0, instrWord[6:0]}
                                                            : instrWord[7:0];
   assign af.accessBit   = instrWord[8];

   address_former former (
      .clk_sys (clk_sys),
      .reset   (reset),
      .af      (af.former)
   );

   // adder for the indexed add, carries taken apart for the flags
   wire logic [4:0] lowSum  = {1'b0, workingReg_q[3:0]} + {1'b0, dataRdData[3:0]};
   wire logic [8:0] fullSum = {1'b0, workingReg_q} + {1'b0, dataRdData};
   wire logic       sumOvf  = (workingReg_q[7] == dataRdData[7])
                              && (fullSum[7] != workingReg_q[7]);

   // data port: the core runs other byte ops on the remapped address
   assign dataAddr   = af.effAddr;
   assign dataRead   = execGo && (byteBitOp || isMove);
   assign dataWrite  = moveDone || (execGo && ((isAdd && destBit) || isPush));
   assign dataWrData = moveDone ? moveByte_q :
                       (execGo && isPush) ? instrWord[7:0] : fullSum[7:0];

   // program flow for call and return
   assign pcLoad        = execGo && (isCall || isReturn);
   assign pcTarget      = isCall ? {counterLatchUpper, counterLatchHigh, workingReg_q}
                                 : topOfReturnStack;
   assign stackPush     = execGo && isCall;
   assign stackPushAddr = nextInstrAddr;
   assign stackPop      = execGo && isReturn;
   assign instrAccept   = state_q != ST_IDLE;

   // sequencing: second move cycle, or the idle cycle after a jump
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_EXEC: begin
            if (execGo && isMove)
               state_d = ST_MOVE_SECOND;
            else if (execGo && (isCall || isReturn))
               state_d = ST_IDLE;
         end
         ST_MOVE_SECOND: begin
            if (instrValid)
               state_d = ST_EXEC;
         end
         ST_IDLE: state_d = ST_EXEC;
         default: state_d = ST_EXEC;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset)
         state_q <= ST_EXEC;
      else
         state_q <= state_d;
   end

   // source byte held between the two move cycles
   always_ff @(posedge clk_sys) begin
      if (reset)
         moveByte_q <= 8'h00;
      else if (execGo && isMove)
         moveByte_q <= dataRdData;
   end

   // working register and flags change only on the add
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         workingReg_q  <= 8'h00;
         statusFlags_q <= 5'h00;
      end else if (execGo && isAdd) begin
         if (!destBit)
            workingReg_q <= fullSum[7:0];
         statusFlags_q[`FLAG_CARRY]       <= fullSum[8];
         statusFlags_q[`FLAG_DIGIT_CARRY] <= lowSum[4];
         statusFlags_q[`FLAG_ZERO]        <= fullSum[7:0] == 8'h00;
         statusFlags_q[`FLAG_OVERFLOW]    <= sumOvf;
         statusFlags_q[`FLAG_NEGATIVE]    <= fullSum[7];
      end
   end

   // one update path per file select pointer
   for (genvar i = 0; i < 3; i++) begin : gen_ptr
      wire logic hitSub = execGo && isSub
                          && ((ptrSel == 2'(i)) || (i == 2 && isReturn));
      wire logic hitPush = (i == 2) && execGo && isPush;
      always_ff @(posedge clk_sys) begin
         if (reset)
            pointer_q[i] <= 12'h000;
         else if (hitSub)
            pointer_q[i] <= pointer_q[i] - {6'h00, subLit};
         else if (hitPush)
            pointer_q[i] <= pointer_q[i] - 12'h001;
      end
   end
   assign fileSelect0       = pointer_q[0];
   assign fileSelect1       = pointer_q[1];
   assign stackFramePointer = pointer_q[2];

   // checks
   sequence moveFirst_s;
      execGo && isMove && dataRead;
   endsequence
   sequence moveSecond_s;
      moveDone;
   endsequence

   ext_mode_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
      captured_q |=> $stable(extOn_q))
      else $error("extension mode changed after capture");
   ext_reset_off_a: assert property (@(posedge clk_sys)
      reset ##1 1'b1 |-> !extOn_q)
      else $error("extension active straight after reset");
   offset_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && byteBitOp && extOn_q && !instrWord[8] && instrWord[7:0] <= 8'h5F)
         |-> dataAddr == pointer_q[2] + {4'h0, instrWord[7:0]})
      else $error("indexed address not frame pointer plus offset");
   add_result_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && isAdd && !destBit) |=> workingReg_q == 8'($past(fullSum))
         && statusFlags_q[`FLAG_CARRY] == $past(fullSum[8]))
      else $error("indexed add result or carry wrong");
   move_pair_a: assert property (@(posedge clk_sys) disable iff (reset)
      moveFirst_s ##1 moveSecond_s |-> dataWrite && dataWrData == $past(dataRdData, 1)
         && dataAddr == pointer_q[2] + {5'h00, instrWord[6:0]}
         && $stable(statusFlags_q))
      else $error("indexed move copied wrong byte or address");
   sub_pointer_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && isSub && ptrSel == 2'h0) |=>
         fileSelect0 == $past(fileSelect0) - {6'h00, $past(subLit)} && $stable(statusFlags_q))
      else $error("pointer subtract wrong");
   push_frame_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && isPush) |-> dataWrite && dataAddr == pointer_q[2]
         ##1 pointer_q[2] == $past(pointer_q[2]) - 12'h001)
      else $error("push did not store then decrement");
   return_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && isReturn) |-> pcLoad && stackPop && pcTarget == topOfReturnStack
         ##1 !instrAccept ##1 instrAccept)
      else $error("return did not load and idle one cycle");
   call_working_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && isCall) |-> stackPush && stackPushAddr == nextInstrAddr
         && pcTarget == {counterLatchUpper, counterLatchHigh, workingReg_q} ##1 !instrAccept)
      else $error("call via working register wrong");
   orphan_nop_a: assert property (@(posedge clk_sys) disable iff (reset)
      (execGo && isOrphan) |-> !dataWrite && !pcLoad ##1 $stable(workingReg_q)
         && $stable(pointer_q[2]))
      else $error("lone second word had an effect");
endmodule : ext_isa_decode

// ==== data_mem_model.sv ====
`timescale 1ns/1ns
module data_mem_model
   import ext_isa_pkg::*;
(
   // clock
   input  wire logic          clk_sys,
   // access from the core
   input  wire data_addr_type dataAddr,
   input  wire logic          dataRead,
   input  wire logic          dataWrite,
   input  wire logic [7:0]    dataWrData,
   output      logic [7:0]    dataRdData
);
   logic [7:0] mem [4096];
   logic [7:0] lastRd_q = 8'h00;
   // address-dependent fill so that a wrong address reads a wrong byte
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)} ^ 8'h5A;
      end
   end
   // same-cycle read; outside a read the bus shows the inverse of the last byte
   assign dataRdData = dataRead ? mem[dataAddr] : ~lastRd_q;
   // writes land at the edge
   always @(posedge clk_sys) begin
      if (dataWrite) begin
         mem[dataAddr] <= dataWrData;
      end
      if (dataRead) begin
         lastRd_q <= mem[dataAddr];
      end
   end
endmodule : data_mem_model

// ==== extended_isa_indexed_offset_decode_tb.sv ====
`timescale 1ns/1ns
module extended_isa_indexed_offset_decode_tb;
   import ext_isa_pkg::*;
   typedef struct packed {
      logic [15:0]   word;
      logic [7:0]    bank;
      data_addr_type onA;
      data_addr_type offA;
   } row_type;
   // stimulus
   logic          clk_sys = 1'b0;
   logic          reset = 1'b1;
   logic          extendedSetEnableBit = 1'b1;
   logic [15:0]   instrWord = 16'h0000;
   logic          instrValid = 1'b0;
   logic [7:0]    bankSelectRegister = 8'h00;
   prog_addr_type nextInstrAddr = 21'h012346;
   prog_addr_type topOfReturnStack = 21'h000ABC;
   logic [7:0]    counterLatchHigh = 8'h10;
   logic [4:0]    counterLatchUpper = 5'h03;
   // observed
   logic          extActive, instrAccept, pcLoad, stackPush, stackPop, dataRead, dataWrite;
   prog_addr_type pcTarget, stackPushAddr;
   data_addr_type dataAddr, fileSelect0, fileSelect1, stackFramePointer;
   logic [7:0]    dataRdData, dataWrData, workingReg_q;
   logic [4:0]    statusFlags_q;
   int            mismatches = 0;
   int            n_checks = 0;
   logic [7:0]    wExp;
   logic [4:0]    fExp;
   // frame pointer FC1h when enabled; absolute address when disabled
   row_type rows [5] = '{
      '{16'h185F, 8'h00, 12'h020, 12'h05F},
      '{16'h1860, 8'h00, 12'hF60, 12'hF60},
      '{16'h1910, 8'h03, 12'h310, 12'h310},
      '{16'h8005, 8'h00, 12'hFC6, 12'h005},
      '{16'h6800, 8'h00, 12'hFC1, 12'h000}};

   ext_isa_decode dut_u (.clk_sys, .reset, .extendedSetEnableBit, .extActive, .instrWord,
      .instrValid, .instrAccept, .bankSelectRegister, .nextInstrAddr, .topOfReturnStack,
      .counterLatchHigh, .counterLatchUpper, .pcLoad, .pcTarget, .stackPush, .stackPushAddr,
      .stackPop, .dataAddr, .dataRead, .dataRdData, .dataWrite, .dataWrData, .workingReg_q,
      .statusFlags_q, .fileSelect0, .fileSelect1, .stackFramePointer);
   data_mem_model mem_u (.clk_sys, .dataAddr, .dataRead, .dataWrite, .dataWrData, .dataRdData);

   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   function automatic logic [7:0] pat(input data_addr_type a);
      return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5A;
   endfunction : pat

   // flags as {N, OV, Z, DC, C}
   function automatic logic [4:0] addFlags(input logic [7:0] w, input logic [7:0] m);
      logic [8:0] s;
      s = {1'b0, w} + {1'b0, m};
      return {s[7], (w[7] == m[7]) && (s[7] != w[7]), s[7:0] == 8'h00,
              ({1'b0, w[3:0]} + {1'b0, m[3:0]}) > 5'h0F, s[8]};
   endfunction : addFlags

   task automatic chkVal(input logic [20:0] got, input logic [20:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chkVal

   task automatic chkBit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chkBit

   // pin must settle well before release; decode switches on one edge after release
   task automatic doReset(input logic en);
      @(posedge clk_sys);
      reset <= 1'b1;
      extendedSetEnableBit <= en;
      instrValid <= 1'b0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : doReset

   // comb outputs are looked at on the falling edge of the same cycle
   task automatic put(input logic [15:0] w, input logic [7:0] b = 8'h00);
      @(posedge clk_sys);
      instrWord <= w;
      instrValid <= 1'b1;
      bankSelectRegister <= b;
      @(negedge clk_sys);
   endtask : put

   task automatic idle();
      @(posedge clk_sys);
      instrValid <= 1'b0;
      @(negedge clk_sys);
   endtask : idle

   task automatic runRows(input logic on);
      data_addr_type aExp;
      foreach (rows[i]) begin
         put(rows[i].word, rows[i].bank);
         aExp = on ? rows[i].onA : rows[i].offA;
         chkVal(21'(dataAddr), 21'(aExp), "remap");
      end
      $display("test rows on=%0b finished", on);
   endtask : runRows

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // watchdog, far beyond the 46 cycles the tests take
   initial begin
      repeat (2000) @(posedge clk_sys);
      mismatches++;
      end_of_test();
   end

   initial begin
      doReset(1'b1);
      chkBit(extActive, 1'b1, "ext on");
      put(16'h2410);
      chkVal(21'(dataAddr), 21'h010, "zero frame");
      chkBit(dataRead, 1'b1, "add read");
      wExp = pat(12'h010);
      fExp = addFlags(8'h00, wExp);
      idle();
      chkVal(21'(workingReg_q), 21'(wExp), "add to W");
      chkVal(21'(statusFlags_q), 21'(fExp), "add flags");
      for (int p = 0; p < 3; p++) begin
         put({8'hE9, 2'(p), (p == 2) ? 6'h3F : 6'(p + 1)});
      end
      idle();
      chkVal(21'(fileSelect0), 21'hFFF, "ptr0");
      chkVal(21'(fileSelect1), 21'hFFE, "ptr1");
      chkVal(21'(stackFramePointer), 21'hFC1, "ptr2");
      chkVal(21'(statusFlags_q), 21'(fExp), "ptr flags");
      $display("test pointers finished");
      runRows(1'b1);
      put(16'h2605);
      chkVal(21'(dataAddr), 21'hFC6, "add d1 addr");
      chkBit(dataWrite, 1'b1, "add d1 write");
      chkVal(21'(dataWrData), 21'(8'(wExp + pat(12'hFC6))), "add d1 data");
      fExp = addFlags(wExp, pat(12'hFC6));
      put(16'hEAA7);
      chkVal(21'(workingReg_q), 21'(wExp), "W kept");
      chkVal(21'(statusFlags_q), 21'(fExp), "overflow flags");
      chkBit(dataWrite, 1'b1, "push write");
      chkVal(21'(dataAddr), 21'hFC1, "push addr");
      chkVal(21'(dataWrData), 21'hA7, "push data");
      put(16'hEBFF);
      chkVal(21'(stackFramePointer), 21'hFC0, "push dec");
      chkBit(dataRead, 1'b1, "move read");
      chkVal(21'(dataAddr), 21'h03F, "move src");
      put(16'hFF81);
      chkBit(dataWrite, 1'b1, "move write");
      chkVal(21'(dataAddr), 21'hFC1, "move dst");
      chkVal(21'(dataWrData), 21'(pat(12'h03F)), "move data");
      put(16'hF123);
      chkBit(dataWrite, 1'b0, "orphan write");
      chkBit(pcLoad, 1'b0, "orphan jump");
      chkVal(21'(statusFlags_q), 21'(fExp), "move flags");
      $display("test data ops finished");
      put(16'h0014);
      chkBit(stackPush, 1'b1, "call push");
      chkVal(stackPushAddr, 21'h012346, "call ret addr");
      chkBit(pcLoad, 1'b1, "call load");
      chkVal(pcTarget, {5'h03, 8'h10, wExp}, "call target");
      idle();
      chkBit(instrAccept, 1'b0, "call idle");
      chkVal(21'(stackFramePointer), 21'hFC0, "orphan ptr");
      idle();
      chkBit(instrAccept, 1'b1, "call resume");
      put(16'hE9C4);
      chkBit(pcLoad, 1'b1, "ret load");
      chkBit(stackPop, 1'b1, "ret pop");
      chkVal(pcTarget, 21'h000ABC, "ret target");
      idle();
      chkBit(instrAccept, 1'b0, "ret idle");
      chkVal(21'(stackFramePointer), 21'hFBC, "ret ptr");
      $display("test flow finished");
      doReset(1'b0);
      chkBit(extActive, 1'b0, "ext off");
      runRows(1'b0);
      put(16'hEAA7);
      chkBit(dataWrite, 1'b0, "plain push word");
      idle();
      chkVal(21'(stackFramePointer), 21'h000, "off ptr");
      $display("test disabled finished");
      end_of_test();
   end
endmodule : extended_isa_indexed_offset_decode_tb
